// ### rtl/ecgm_pkg.sv
package ecgm_pkg;
  localparam int NUM_CHANNELS = 6;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] GEN_OFF = 8'h00;
  localparam logic [7:0] GEN_SYNC_CHAR = 8'h01;
  localparam logic [7:0] GEN_TAP_BASE = 8'h08;
  localparam logic [7:0] GEN_ACMP = 8'h20;
  localparam logic [7:0] GEN_RESULT = 8'h24;
  localparam logic [7:0] GEN_SAMPLE = 8'h25;
  localparam logic [7:0] GEN_WINDOW = 8'h26;
  localparam logic [7:0] GEN_PIN_LOW = 8'h40;
  localparam logic [7:0] GEN_PIN_HIGH = 8'h48;
  localparam logic [7:0] GEN_XCK0 = 8'h60;
  localparam logic [7:0] GEN_XCK1 = 8'h61;
  localparam logic [7:0] GEN_SPI_SCK = 8'h68;
  localparam logic [7:0] GEN_OVERFLOW_OR_LOW_UNDERFLOW = 8'h80;
  localparam logic [7:0] GEN_HIGH_BYTE_UNDERFLOW = 8'h81;
  localparam logic [7:0] GEN_CMP0 = 8'h84;
  localparam logic [7:0] GEN_CMP1 = 8'h85;
  localparam logic [7:0] GEN_CMP2 = 8'h86;
  localparam logic [7:0] GEN_CT1_CAPTURE_FLAG_EVENT = 8'hA0;
  localparam logic [7:0] GEN_CT1_OVF = 8'hA1;
  localparam logic [7:0] GEN_CT2_CAPTURE_FLAG_EVENT = 8'hA2;
  localparam logic [7:0] GEN_CT2_OVF = 8'hA3;
  localparam int SYNC_STAGES = 2;

  // periodic taps: bit 0..7 = div8192,4096,2048,1024,512,256,128,64
  typedef struct packed {
    logic [7:0] periodic_tap;
    logic analog_comparator;
    logic [7:0] port_a;
    logic [7:0] port_b;
    logic [7:0] port_c;
    logic [7:0] port_a_in_en;
    logic [7:0] port_b_in_en;
    logic [7:0] port_c_in_en;
  } ecgm_async_gen_t;

  typedef struct packed {
    logic sync_char_detect;
    logic result_ready;
    logic sample_ready;
    logic window_compare_match;
    logic [1:0] serial_transfer_clock;
    logic spi_sck;
    logic wide_timer_split;
    logic overflow_or_low_underflow;
    logic high_byte_underflow;
    logic [2:0] compare_match;
    logic [1:0] capture_flag_event;
    logic [1:0] overflow_event;
  } ecgm_sync_gen_t;
endpackage

// ### rtl/ecgm_sync.sv
`timescale 1ns/1ps
module ecgm_sync #(
  parameter int STAGES = 2
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic async_i,
  output logic sync_o
);
  logic [STAGES-1:0] chain;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      chain <= '0;
    end else begin
      chain <= {chain[STAGES-2:0], async_i};
    end
  end

  assign sync_o = chain[STAGES-1];
endmodule // ecgm_sync

// ### rtl/ecgm_mux.sv
`timescale 1ns/1ps
module ecgm_mux
  import ecgm_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [CHANNELS-1:0] sel_write_i,
  input wire logic [7:0] sel_data_i,
  input wire ecgm_pkg::ecgm_async_gen_t async_gen_i,
  input wire ecgm_pkg::ecgm_sync_gen_t sync_gen_i,
  output logic [CHANNELS*8-1:0] channel_generator_select_o,
  output logic [CHANNELS-1:0] channel_async_o,
  output logic [CHANNELS-1:0] channel_sync_o
);
  import ecgm_pkg::*;

  wire [7:0] pin_a = async_gen_i.port_a & async_gen_i.port_a_in_en;
  wire [7:0] pin_b = async_gen_i.port_b & async_gen_i.port_b_in_en;
  wire [7:0] pin_c = async_gen_i.port_c & async_gen_i.port_c_in_en;

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
      logic [7:0] channel_generator_select;
      logic async_src;
      logic sync_src;
      logic is_async;
      logic synced;
      wire [2:0] low3 = channel_generator_select[2:0];
      wire [1:0] tap_idx = channel_generator_select[1:0];
      wire is_tap = channel_generator_select[7:2] == GEN_TAP_BASE[7:2];
      wire is_pin_lo = channel_generator_select[7:3] == GEN_PIN_LOW[7:3];
      wire is_pin_hi = channel_generator_select[7:3] == GEN_PIN_HIGH[7:3];
      // channel pair index 0: ch0/1, 1: ch2/3, 2: ch4/5
      wire [1:0] pair = 2'(ch / 2);
      wire odd = 1'(ch % 2);
      wire [7:0] pin_lo_bank = (pair == 2'd0) ? pin_a :
                               (pair == 2'd1) ? pin_c : pin_b;
      wire [7:0] pin_hi_bank = (pair == 2'd0) ? pin_b :
                               (pair == 2'd1) ? pin_a : pin_c;

      always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
          channel_generator_select <= SEL_RESET;
        end else if (sel_write_i[ch]) begin
          channel_generator_select <= sel_data_i;
        end
      end

      always_comb begin
        async_src = 1'b0;
        is_async = 1'b0;
        if (is_tap) begin
          is_async = 1'b1;
          async_src = async_gen_i.periodic_tap[{odd, tap_idx}];
        end else if (channel_generator_select == GEN_ACMP) begin
          is_async = 1'b1;
          async_src = async_gen_i.analog_comparator;
        end else if (is_pin_lo) begin
          is_async = 1'b1;
          async_src = pin_lo_bank[low3];
        end else if (is_pin_hi) begin
          is_async = 1'b1;
          async_src = pin_hi_bank[low3];
        end
      end

      always_comb begin
        // off and unknown codes stay low
        sync_src = 1'b0;
        case (channel_generator_select)
          GEN_SYNC_CHAR: sync_src = sync_gen_i.sync_char_detect;
          GEN_RESULT: sync_src = sync_gen_i.result_ready;
          GEN_SAMPLE: sync_src = sync_gen_i.sample_ready;
          GEN_WINDOW: sync_src = sync_gen_i.window_compare_match;
          GEN_XCK0: sync_src = sync_gen_i.serial_transfer_clock[0];
          GEN_XCK1: sync_src = sync_gen_i.serial_transfer_clock[1];
          GEN_SPI_SCK: sync_src = sync_gen_i.spi_sck;
          GEN_OVERFLOW_OR_LOW_UNDERFLOW: sync_src = sync_gen_i.overflow_or_low_underflow;
          GEN_HIGH_BYTE_UNDERFLOW: sync_src = sync_gen_i.wide_timer_split &
                               sync_gen_i.high_byte_underflow;
          GEN_CMP0: sync_src = sync_gen_i.compare_match[0];
          GEN_CMP1: sync_src = sync_gen_i.compare_match[1];
          GEN_CMP2: sync_src = sync_gen_i.compare_match[2];
          GEN_CT1_CAPTURE_FLAG_EVENT: sync_src = sync_gen_i.capture_flag_event[0];
          GEN_CT1_OVF: sync_src = sync_gen_i.overflow_event[0];
          GEN_CT2_CAPTURE_FLAG_EVENT: sync_src = sync_gen_i.capture_flag_event[1];
          GEN_CT2_OVF: sync_src = sync_gen_i.overflow_event[1];
          default: sync_src = 1'b0;
        endcase
      end

      ecgm_sync #(
        .STAGES(SYNC_STAGES)
      ) u_sync (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .async_i(async_src),
        .sync_o(synced)
      );

      assign channel_async_o[ch] = is_async ? async_src : sync_src;
      assign channel_sync_o[ch] = is_async ? synced : sync_src;
      assign channel_generator_select_o[ch*8 +: 8] =
        channel_generator_select;
    end
  endgenerate
endmodule // ecgm_mux

// ### test/ecgm_mux_properties.sv
`timescale 1ns/1ps
module ecgm_mux_properties
  import ecgm_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [CHANNELS-1:0] sel_write_i,
  input wire logic [7:0] sel_data_i,
  input wire ecgm_pkg::ecgm_async_gen_t async_gen_i,
  input wire ecgm_pkg::ecgm_sync_gen_t sync_gen_i,
  input wire logic [CHANNELS*8-1:0] channel_generator_select_o,
  input wire logic [CHANNELS-1:0] channel_async_o,
  input wire logic [CHANNELS-1:0] channel_sync_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  wire [7:0] s0 = channel_generator_select_o[7:0];
  wire [7:0] s1 = channel_generator_select_o[15:8];
  wire [7:0] s4 = channel_generator_select_o[39:32];
  sel_load_a: assert property (sel_write_i[0] |=> s0 == $past(sel_data_i))
    else $error("write lost");
  sel_hold_a: assert property (!sel_write_i[1] |=> $stable(s1))
    else $error("selector drift");
  off_low_a: assert property (s0 == 8'h00 |-> !channel_async_o[0])
    else $error("idle not low");
  sync_char_a: assert property (s0 == 8'h01 |->
    channel_sync_o[0] == sync_gen_i.sync_char_detect) else $error("sync char");
  cmp_route_a: assert property (s1 == 8'h20 |->
    channel_async_o[1] == async_gen_i.analog_comparator) else $error("cmp");
  // a two-flop path; a third flop would slip past the stated bound
  sync_lag_a: assert property (s1 == 8'h20 [*3] |->
    channel_sync_o[1] == $past(async_gen_i.analog_comparator, 2))
    else $error("sync lag");
  tap_even_a: assert property (s0 == 8'h08 |->
    channel_async_o[0] == async_gen_i.periodic_tap[0]) else $error("tap");
  split_gate_a: assert property (s4 == 8'h81 |-> channel_async_o[4] ==
    (sync_gen_i.high_byte_underflow && sync_gen_i.wide_timer_split))
    else $error("split gate");
  cover property (&sel_write_i);
  cover property (s1 == 8'h20 && channel_sync_o[1]);
  cover property (s4 == 8'h81 && channel_async_o[4]);
endmodule // ecgm_mux_properties
bind ecgm_mux ecgm_mux_properties #(.CHANNELS(CHANNELS)) u_prop (.clk_sys_i,
  .reset_i, .sel_write_i, .sel_data_i, .async_gen_i, .sync_gen_i,
  .channel_generator_select_o, .channel_async_o, .channel_sync_o);

// ### test/ecgm_gen_model.sv
`timescale 1ns/1ps
// one-hot sources, so a wrong route reads as a clean zero
module ecgm_gen_model
  import ecgm_pkg::*;
(
  input wire logic [6:0] idx_i,
  input wire logic en_off_i,
  input wire logic split_i,
  output ecgm_pkg::ecgm_async_gen_t async_gen_o,
  output ecgm_pkg::ecgm_sync_gen_t sync_gen_o
);
  logic [73:0] gen;
  assign gen = (74'h1 << idx_i) | {33'h0, {24{!en_off_i}}, 17'h0}
    | {64'h0, split_i, 9'h0};
  assign {async_gen_o, sync_gen_o} = gen;
endmodule // ecgm_gen_model

// ### test/tb_event_channel_generator_mux.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module tb_event_channel_generator_mux;
  import ecgm_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [5:0] wr_en = 6'h00;
  logic [7:0] wr_data = 8'h00;
  logic [6:0] idx = 7'h00;
  logic en_off = 1'b0;
  logic split = 1'b1;
  ecgm_async_gen_t agen;
  ecgm_sync_gen_t sgen;
  logic [47:0] sel_o;
  logic [5:0] aout;
  logic [5:0] sout;
  int errors = 0;
  int total_checks = 0;
  int c;
  // channel, code, source bit, expected level
  logic [23:0] rows [31] = '{24'h001101, 24'h008421, 24'h20B451,
    24'h108461, 24'h50B491, 24'h120411, 24'h0240F1, 24'h1250E1, 24'h2260D1,
    24'h040391, 24'h34F401, 24'h447381, 24'h048311, 24'h240291, 24'h54F301,
    24'h0600B1, 24'h1610C1, 24'h2680A1, 24'h380081, 24'h481071, 24'h584041,
    24'h085051, 24'h186061, 24'h2A0021, 24'h3A1001, 24'h4A2031, 24'h5A3011,
    24'h440390, 24'h10B450, 24'h006490, 24'h000100};
  always #10 clk_sys_i = ~clk_sys_i;
  ecgm_gen_model gen (.idx_i(idx), .en_off_i(en_off), .split_i(split),
    .async_gen_o(agen), .sync_gen_o(sgen));
  ecgm_mux uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .sel_write_i(wr_en), .sel_data_i(wr_data), .async_gen_i(agen),
    .sync_gen_i(sgen), .channel_generator_select_o(sel_o),
    .channel_async_o(aout), .channel_sync_o(sout));
  task automatic wr(input logic [5:0] m, input logic [7:0] d,
    input logic [6:0] s, input int n);
    wr_en = m;
    wr_data = d;
    @(negedge clk_sys_i);
    wr_en = 6'h00;
    idx = s;
    repeat (n) @(negedge clk_sys_i);
  endtask
  task print_verdict;
    if (errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    print_verdict;
  end
  initial begin
    repeat (2) @(negedge clk_sys_i);
    reset_i = 1'b0;
    foreach (rows[i]) begin
      c = rows[i][23:20];
      // three cycles covers the slowest synchronised source
      wr(6'h01 << c, rows[i][19:12], rows[i][10:4], 3);
      `CHK({aout[c], sout[c]}, {2{rows[i][0]}})
      `CHK(sel_o[c*8 +: 8], rows[i][19:12])
      `CHK(sout[c], rows[i][0])
    end
    en_off = 1'b1;
    wr(6'h01, 8'h40, 7'h39, 3);
    `CHK({aout[0], sout[0]}, 2'b00)
    en_off = 1'b0;
    split = 1'b0;
    wr(6'h10, 8'h81, 7'h07, 3);
    `CHK(aout[4], 1'b0)
    wr(6'h3F, 8'h20, 7'h41, 1);
    `CHK(aout, 6'h3F)
    `CHK(sout, 6'h00)
    @(negedge clk_sys_i);
    `CHK(sout, 6'h3F)
    reset_i = 1'b1;
    @(negedge clk_sys_i);
    `CHK({sel_o, aout, sout}, 60'h0)
    print_verdict;
  end
endmodule // tb_event_channel_generator_mux
